// File: shared/alarm_gate_consts.vh
`ifndef ALARM_GATE_CONSTS_VH
`define ALARM_GATE_CONSTS_VH
// Register offsets (word addresses on the plain register port)
`define SUPPLY_GATE_ADDR 8'h47
`define CLOCK_GATE_ADDR 8'h48
`define ALARM_STATUS_ADDR 8'h50
`define ALARM_ENABLE_ADDR 8'h51
// Reset values
`define SUPPLY_GATE_RST 16'h0000
`define CLOCK_GATE_RST 16'h0000
`define ALARM_ENABLE_RST 2'h0
// Supply gate field positions
`define SG_ANALOG_OV 15
`define SG_ANALOG_UV 14
`define SG_IO_OV 13
`define SG_IO_UV 12
`define SG_DIG_OV 11
`define SG_DIG_UV 10
`define SG_ANALOG_OSC 9
`define SG_IO_OSC 8
`define SG_DIG_OSC 7
`define SG_ANALOG_HOT 6
`define SG_IO_HOT 5
`define SG_ANALOG_CL 4
`define SG_IO_CL 3
`define SG_GND_A 2
`define SG_GND_B 1
`define SG_GND_D 0
// Clock gate field positions
`define CG_SPARE_HI 15
`define CG_SPARE_LO 10
`define CG_RATE 2
`define CG_DIAG_WD 1
`define CG_MAIN_WD 0
// Mask of writable clock gate bits; bits 9:3 stay zero
`define CG_WRITABLE 16'hfc07
// Status and enable bit positions
`define ST_SUPPLY 0
`define ST_CLOCK 1
`endif

// File: hw/alarm_combine.v
`timescale 1ns/1ps
// Masked OR of a group of fault flags
module alarm_combine #(
  parameter WIDTH = 16
) (
  // Flags and their masks
  input wire [WIDTH-1:0] flags,
  input wire [WIDTH-1:0] mask,
  // Combined result
  output wire summary
);
  wire [WIDTH-1:0] pass;
  genvar i;
  // A zero mask lets a flag through, a one suppresses it
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      assign pass[i] = flags[i] & ~mask[i];
    end
  endgenerate
  assign summary = |pass;
endmodule // alarm_combine

// File: hw/supply_clock_fault_gating.v
`timescale 1ns/1ps
`include "alarm_gate_consts.vh"
// Behaviour
// - Bits 15/14 mask analog over/under volt
// - Bits 13/12 mask I/O over/under volt
// - Bits 11/10 mask digital over/under volt
// - Bits 9/8/7 mask rail oscillation flags
// - Bits 6/5 mask regulator hot warnings
// - Bits 4/3 mask regulator current limits
// - Bits 2/1/0 mask ground open flags
// - Zero passes flag, one suppresses it
// - Clock bit 2 masks main clock rate
// - Clock bit 1 masks diag oscillator watchdog
// - Clock bit 0 masks main clock watchdog
// - Clock gate at 48h, resets 0000h
// - Clock gate bits 9:3 read zero
module supply_clock_fault_gating (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Register port
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata_q,
  // Supply fault flags, active high
  input wire analog_rail_over_volt,
  input wire analog_rail_under_volt,
  input wire io_rail_over_volt,
  input wire io_rail_under_volt,
  input wire digital_rail_over_volt,
  input wire digital_rail_under_volt,
  input wire analog_rail_oscillation,
  input wire io_rail_oscillation,
  input wire digital_rail_oscillation,
  input wire analog_regulator_hot_warning,
  input wire io_regulator_hot_warning,
  input wire analog_regulator_current_limit,
  input wire io_regulator_current_limit,
  input wire analog_ground_a_open,
  input wire analog_ground_b_open,
  input wire digital_ground_open,
  // Clock fault flags, active high
  input wire main_clock_rate_error,
  input wire diag_oscillator_watchdog_error,
  input wire main_clock_watchdog_error,
  // Summary alarms and interrupt
  output reg supply_summary_alarm_q,
  output reg clock_summary_alarm_q,
  output reg irq_q
);
  reg [15:0] supply_gate_q;
  reg [15:0] clock_gate_q;
  reg [1:0] status_q;
  reg [1:0] status_d;
  reg [1:0] enable_q;
  reg [1:0] sum_prev_q;
  reg [15:0] rdata_d;
  wire [15:0] supply_flags;
  wire [15:0] clock_flags;
  wire supply_sum;
  wire clock_sum;
  wire [1:0] rise;
  wire status_rd;

  // Pack supply flags at the positions of their mask bits
  assign supply_flags[`SG_ANALOG_OV] = analog_rail_over_volt;
  assign supply_flags[`SG_ANALOG_UV] = analog_rail_under_volt;
  assign supply_flags[`SG_IO_OV] = io_rail_over_volt;
  assign supply_flags[`SG_IO_UV] = io_rail_under_volt;
  assign supply_flags[`SG_DIG_OV] = digital_rail_over_volt;
  assign supply_flags[`SG_DIG_UV] = digital_rail_under_volt;
  assign supply_flags[`SG_ANALOG_OSC] = analog_rail_oscillation;
  assign supply_flags[`SG_IO_OSC] = io_rail_oscillation;
  assign supply_flags[`SG_DIG_OSC] = digital_rail_oscillation;
  assign supply_flags[`SG_ANALOG_HOT] = analog_regulator_hot_warning;
  assign supply_flags[`SG_IO_HOT] = io_regulator_hot_warning;
  assign supply_flags[`SG_ANALOG_CL] = analog_regulator_current_limit;
  assign supply_flags[`SG_IO_CL] = io_regulator_current_limit;
  assign supply_flags[`SG_GND_A] = analog_ground_a_open;
  assign supply_flags[`SG_GND_B] = analog_ground_b_open;
  assign supply_flags[`SG_GND_D] = digital_ground_open;

  // Clock flags; spare and reserved positions carry no source
  assign clock_flags[15:3] = 13'h0000;
  assign clock_flags[`CG_RATE] = main_clock_rate_error;
  assign clock_flags[`CG_DIAG_WD] = diag_oscillator_watchdog_error;
  assign clock_flags[`CG_MAIN_WD] = main_clock_watchdog_error;

  // Gating leaves the source flags untouched; only the summary is masked
  alarm_combine #(
    .WIDTH(16)
  ) u_supply (
    .flags(supply_flags),
    .mask(supply_gate_q),
    .summary(supply_sum)
  );

  alarm_combine #(
    .WIDTH(16)
  ) u_clock (
    .flags(clock_flags),
    .mask(clock_gate_q),
    .summary(clock_sum)
  );

  // Mask register writes
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      supply_gate_q <= `SUPPLY_GATE_RST;
      clock_gate_q <= `CLOCK_GATE_RST;
      enable_q <= `ALARM_ENABLE_RST;
    end else if (wr) begin
      case (addr)
        `SUPPLY_GATE_ADDR: begin
          supply_gate_q <= wdata;
        end
        `CLOCK_GATE_ADDR: begin
          // Bits 9:3 are never stored, spare bits 15:10 are
          clock_gate_q <= wdata & `CG_WRITABLE;
        end
        `ALARM_ENABLE_ADDR: begin
          enable_q <= wdata[1:0];
        end
        default: begin
          supply_gate_q <= supply_gate_q;
        end
      endcase
    end
  end

  // Summary bits are registered so outputs come from flip-flops
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      supply_summary_alarm_q <= 1'b0;
      clock_summary_alarm_q <= 1'b0;
      sum_prev_q <= 2'h0;
    end else begin
      supply_summary_alarm_q <= supply_sum;
      clock_summary_alarm_q <= clock_sum;
      sum_prev_q <= {clock_sum, supply_sum};
    end
  end

  // A summary rising edge is the event; a long-held fault raises it once
  assign rise = {clock_sum, supply_sum} & ~sum_prev_q;
  assign status_rd = rd && (addr == `ALARM_STATUS_ADDR);

  // Read clears status, but a new event in the same cycle wins
  always @* begin
    status_d = status_q;
    if (status_rd) begin
      status_d = 2'h0;
    end
    status_d = status_d | rise;
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q <= |(status_d & enable_q);
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    rdata_d = 16'h0000;
    case (addr)
      `SUPPLY_GATE_ADDR: begin
        rdata_d = supply_gate_q;
      end
      `CLOCK_GATE_ADDR: begin
        rdata_d = clock_gate_q & `CG_WRITABLE;
      end
      `ALARM_STATUS_ADDR: begin
        rdata_d = {14'h0000, status_q};
      end
      `ALARM_ENABLE_ADDR: begin
        rdata_d = {14'h0000, enable_q};
      end
      default: begin
        rdata_d = 16'h0000;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 16'h0000;
    end else if (rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 16'h0000;
    end
  end
endmodule // supply_clock_fault_gating

// File: tb/alarm_gate_checker.sv
`timescale 1ns/1ps
// Port-side checker; the masks are shadowed from the writes seen on the port
module alarm_gate_checker (
  // Clock, reset and register port
  input wire clock, resetn, wr, rd,
  input wire [7:0] addr,
  input wire [15:0] wdata, rdata_q,
  // A sample of flags, and the summaries
  input wire io_rail_over_volt, digital_ground_open,
  input wire main_clock_rate_error, main_clock_watchdog_error,
  input wire supply_summary_alarm_q, clock_summary_alarm_q
);
  reg [15:0] sm_q, cm_q;
  // Shadow masks; only a port write may change them
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sm_q <= 16'h0;
      cm_q <= 16'h0;
    end else if (wr && addr == 8'h47) sm_q <= wdata;
    else if (wr && addr == 8'h48) cm_q <= wdata;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence rd_clk_s; rd && addr == 8'h48; endsequence
  sequence rd_sup_s; rd && addr == 8'h47; endsequence
  io_ov_pass_a:
    assert property (!sm_q[13] && io_rail_over_volt |=> supply_summary_alarm_q)
    else $error("io over volt not summarised");
  gnd_pass_a:
    assert property (!sm_q[0] && digital_ground_open |=> supply_summary_alarm_q)
    else $error("ground open not summarised");
  rate_pass_a:
    assert property (!cm_q[2] && main_clock_rate_error |=> clock_summary_alarm_q)
    else $error("clock rate error not summarised");
  main_wd_pass_a:
    assert property (!cm_q[0] && main_clock_watchdog_error
      |=> clock_summary_alarm_q) else $error("watchdog not summarised");
  supply_block_a:
    assert property (&sm_q |=> !supply_summary_alarm_q)
    else $error("masked supply flag leaked");
  clock_block_a:
    assert property (&cm_q[2:0] |=> !clock_summary_alarm_q)
    else $error("masked clock flag leaked");
  clock_read_a:
    assert property (rd_clk_s |=> rdata_q == (cm_q & 16'hfc07))
    else $error("clock gate read wrong");
  supply_read_a:
    assert property (rd_sup_s |=> rdata_q == sm_q)
    else $error("supply gate read wrong");
endmodule // alarm_gate_checker
bind supply_clock_fault_gating alarm_gate_checker alarm_gate_checker_i (
  .clock(clock), .resetn(resetn), .wr(wr), .rd(rd), .addr(addr),
  .wdata(wdata), .rdata_q(rdata_q), .io_rail_over_volt(io_rail_over_volt),
  .digital_ground_open(digital_ground_open),
  .main_clock_rate_error(main_clock_rate_error),
  .main_clock_watchdog_error(main_clock_watchdog_error),
  .supply_summary_alarm_q(supply_summary_alarm_q),
  .clock_summary_alarm_q(clock_summary_alarm_q));

// File: tb/tb_supply_clock_fault_gating.sv
`timescale 1ns/1ps
module tb_supply_clock_fault_gating;
  logic clock = 0, resetn = 0, wr = 0, rd = 0;
  logic [7:0] addr = 8'h0;
  logic [15:0] wdata = 16'h0;
  logic [18:0] fl = 19'h0;
  wire [15:0] rdata_q;
  wire sup, clk, irq_q;
  int mismatches = 0, n_tests = 0, cyc = 0;
  // Flags 15:0 are the supply group, 18:16 the clock group
  supply_clock_fault_gating supply_clock_fault_gating_i (.clock(clock),
    .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .analog_rail_over_volt(fl[15]),
    .analog_rail_under_volt(fl[14]), .io_rail_over_volt(fl[13]),
    .io_rail_under_volt(fl[12]), .digital_rail_over_volt(fl[11]),
    .digital_rail_under_volt(fl[10]), .analog_rail_oscillation(fl[9]),
    .io_rail_oscillation(fl[8]), .digital_rail_oscillation(fl[7]),
    .analog_regulator_hot_warning(fl[6]), .io_regulator_hot_warning(fl[5]),
    .analog_regulator_current_limit(fl[4]),
    .io_regulator_current_limit(fl[3]), .analog_ground_a_open(fl[2]),
    .analog_ground_b_open(fl[1]), .digital_ground_open(fl[0]),
    .main_clock_rate_error(fl[18]),
    .diag_oscillator_watchdog_error(fl[17]),
    .main_clock_watchdog_error(fl[16]), .supply_summary_alarm_q(sup),
    .clock_summary_alarm_q(clk), .irq_q(irq_q));
  always #2 clock = ~clock;
  // Cut a hang short; the whole run needs well under 1000 cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      summarize;
    end
  end
  task chk(input [15:0] g, input [15:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr_t(input [7:0] a, input [15:0] d);
    @(posedge clock);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task rd_t(input [7:0] a, input [15:0] e);
    @(posedge clock);
    addr <= a; rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata_q, e);
  endtask
  task t_reset;
    rd_t(8'h48, 16'h0000);
    rd_t(8'h47, 16'h0000);
    $display("reset values done");
  endtask
  // Raise, clear and mask the interrupt through sticky status
  task t_irq;
    wr_t(8'h51, 16'h0003);
    fl <= 19'h00001;
    repeat (3) @(posedge clock);
    #1 chk(irq_q, 1'b1);
    rd_t(8'h50, 16'h0001);
    @(posedge clock);
    #1 chk(irq_q, 1'b0);
    wr_t(8'h51, 16'h0001);
    fl <= 19'h40001;
    repeat (3) @(posedge clock);
    #1 chk(irq_q, 1'b0);
    rd_t(8'h50, 16'h0002);
    rd_t(8'h51, 16'h0001);
    fl <= 19'h0;
    $display("interrupt done");
  endtask
  // Each flag alone: passes unmasked, blocked by its own bit only
  task t_sweep;
    logic [7:0] a;
    logic [15:0] b;
    logic [15:0] c;
    for (int i = 0; i < 19; i++) begin
      a = (i < 16) ? 8'h47 : 8'h48;
      b = 16'h1 << ((i < 16) ? i : i - 16);
      // Third pass masks all other sources; clock spare bits stay zero
      c = (a[0] ? 16'hffff : 16'h0007) & ~b;
      fl <= 19'h1 << i;
      for (int m = 0; m < 3; m++) begin
        wr_t(a, m == 0 ? 16'h0 : m == 1 ? b : c);
        repeat (2) @(posedge clock);
        #1;
        if (i < 16) chk(sup, m != 1);
        else chk(clk, m != 1);
        chk(i < 16 ? clk : sup, 1'b0);
      end
      wr_t(a, 16'h0);
    end
    fl <= 19'h0;
    $display("gating sweep done");
  endtask
  task t_reg;
    wr_t(8'h48, 16'hffff);
    rd_t(8'h48, 16'hfc07);
    // Read data must fall back to zero one cycle after it stood
    @(posedge clock);
    #1 chk(rdata_q, 16'h0000);
    rd_t(8'h60, 16'h0000);
    wr_t(8'h48, 16'h0000);
    rd_t(8'h48, 16'h0000);
    $display("register access done");
  endtask
  // Every flag raised with every flag's mask bit set, clock spare bits left zero: both summaries stay low
  task t_mask_all;
    wr_t(8'h47, 16'hffff);
    wr_t(8'h48, 16'h0007);
    fl <= 19'h7ffff;
    repeat (2) @(posedge clock);
    #1 chk(sup, 1'b0);
    chk(clk, 1'b0);
    wr_t(8'h48, 16'h0000);
    repeat (2) @(posedge clock);
    #1 chk(clk, 1'b1);
    wr_t(8'h47, 16'h0000);
    fl <= 19'h0;
    $display("all masked done");
  endtask
  task summarize;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    t_reset;
    t_irq;
    t_sweep;
    t_mask_all;
    t_reg;
    summarize;
  end
endmodule // tb_supply_clock_fault_gating
